// file: design/mcp_motion_command_params.sv
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/100ps
// Summary of operation
// [R1] Manual travel current limited, default 1000
// [R2] Start write: bit0 positive, bit1 negative, bit2 fast
// [R3] Travel type 0 mode one, 1 mode two
// [R4] Slow manual speed, range checked, default 60
// [R5] Fast manual speed, range checked, default 180
// [R6] Jog cycle distance, default 20
// [R7] Manual start begins with fixed step
// [R8] Mode one waits configured milliseconds
// [R9] Speed command write starts or changes profile
// [R10] Speed status: reached, end, error, error bits
// [R11] Absolute command write starts absolute move
// [R12] Relative command write starts relative move
// [R13] Resume write continues interrupted move, value ignored
// [R14] Point moves use configured point speed
// [R15] Manual and point status share error layout
module mcp_motion_command_params #(
	parameter int CYC_PER_MS = mcp_pkg::CYC_PER_MS,
	parameter logic [31:0] DEF_PTP_SPEED = mcp_pkg::RST_PTP_SPEED
) (
	input wire logic clk_i, // System clock.
	input wire logic sys_rst_i, // Synchronous reset, active high.
	input wire logic [7:0] reg_addr_i, // Register byte address.
	input wire logic [31:0] reg_wdata_i, // Write data.
	input wire logic reg_we_i, // Write strobe.
	input wire logic reg_re_i, // Read strobe.
	output logic [31:0] reg_rdata_o, // Read data, cycle after strobe.
	input wire logic [7:0] axis_err_i, // Axis error flags, asynchronous.
	input wire logic axis_reached_i, // Axis at setpoint, asynchronous.
	input wire logic axis_done_i, // Axis motion finished, asynchronous.
	output mcp_pkg::mcp_move_t move_kind_o, // Kind of motion commanded.
	output logic move_start_o, // Pulse: take new motion values.
	output logic move_stop_o, // Pulse: halt the axis.
	output logic move_resume_o, // Pulse: resume halted point move.
	output logic move_relative_o, // Target is a distance.
	output logic move_endless_o, // Travel without distance limit.
	output logic move_neg_o, // Negative sense of rotation.
	output logic [31:0] move_speed_o, // Signed setpoint speed.
	output logic [31:0] move_target_o, // Position or distance.
	output logic [15:0] current_limit_o, // Current limit, 100 per amp peak.
	output logic irq_o // Interrupt, level, active high.
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations.
	typedef enum logic [2:0] {
		S_IDLE, S_MAN_STEP, S_MAN_WAIT, S_MAN_RUN, S_VEL, S_PTP, S_PTP_HALT
	} mcp_state_t;

	mcp_state_t state_q; // Motion sequencer state.
	logic [15:0] cur_limit_q; // Manual current limit.
	logic [15:0] man_start_q; // Last manual start word.
	logic [15:0] man_type_q; // Manual travel type.
	logic [31:0] slow_speed_q; // Slow manual speed.
	logic [31:0] fast_speed_q; // Fast manual speed.
	logic [15:0] jog_dist_q; // Distance per jog cycle.
	logic [15:0] jog_step_q; // Step at manual start.
	logic [15:0] wait_time_q; // Mode one wait in ms.
	logic [31:0] speed_cmd_q; // Last speed command.
	logic [31:0] abs_cmd_q; // Last absolute target.
	logic [31:0] rel_cmd_q; // Last relative distance.
	logic [15:0] resume_cmd_q; // Last resume word, unused by motion.
	logic [31:0] ptp_speed_q; // Point move speed.
	logic [15:0] man_stat_q; // Manual status word.
	logic [15:0] vel_stat_q; // Speed profile status word.
	logic [15:0] ptp_stat_q; // Point move status word.
	localparam int IRQ_W_L = mcp_pkg::IRQ_W;
	logic [IRQ_W_L-1:0] irq_stat_q; // Sticky events.
	logic [IRQ_W_L-1:0] irq_mask_q; // Event enables.
	logic [IRQ_W_L-1:0] irq_set; // Events this cycle.
	logic [9:0] sync1_q, sync2_q, sync3_q; // Input synchroniser stages.
	logic [9:0] in_q; // Filtered axis inputs.
	logic [9:0] in_prev_q; // Previous filtered inputs.
	logic [31:0] ms_cyc_q; // Cycles within a millisecond.
	logic [15:0] ms_left_q; // Milliseconds left to wait.

	// Decoded write strobes.
	logic wr_man_start, wr_speed, wr_abs, wr_rel, wr_resume;
	logic [15:0] err_bits; // Axis error flags in status layout.
	logic any_err, err_rise, done_rise, reached_rise;
	logic man_pos, man_neg, man_fast;

	always_comb begin
		wr_man_start = reg_we_i && (reg_addr_i == mcp_pkg::ADDR_MAN_START);
		wr_speed = reg_we_i && (reg_addr_i == mcp_pkg::ADDR_SPEED_CMD);
		wr_abs = reg_we_i && (reg_addr_i == mcp_pkg::ADDR_ABS_CMD);
		wr_rel = reg_we_i && (reg_addr_i == mcp_pkg::ADDR_REL_CMD);
		wr_resume = reg_we_i && (reg_addr_i == mcp_pkg::ADDR_RESUME_CMD);
		err_bits = {8'h00, in_q[7:0]} & mcp_pkg::ERR_FIELD_MASK; // [R10] [R15]
		any_err = |err_bits;
		err_rise = any_err && !(|({8'h00, in_prev_q[7:0]} & mcp_pkg::ERR_FIELD_MASK));
		reached_rise = in_q[8] && !in_prev_q[8];
		done_rise = in_q[9] && !in_prev_q[9];
		man_pos = reg_wdata_i[mcp_pkg::MAN_POS_BIT]; // [R2]
		man_neg = reg_wdata_i[mcp_pkg::MAN_NEG_BIT]; // [R2]
		man_fast = reg_wdata_i[mcp_pkg::MAN_FAST_BIT]; // [R2]
	end

	////////////////////////////////////////////////////////////////////////////////
	// Axis inputs: three stages, a change is taken once stages two and three agree.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			sync1_q <= 10'h000;
			sync2_q <= 10'h000;
			sync3_q <= 10'h000;
			in_q <= 10'h000;
			in_prev_q <= 10'h000;
		end else begin
			sync1_q <= {axis_done_i, axis_reached_i, axis_err_i};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			in_q <= (sync2_q & sync3_q) |
				(in_q & (sync2_q ^ sync3_q));
			in_prev_q <= in_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Configuration registers; out of range writes are ignored.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cur_limit_q <= mcp_pkg::RST_CUR_LIMIT; // [R1]
			man_type_q <= mcp_pkg::RST_MAN_TYPE; // [R3]
			slow_speed_q <= mcp_pkg::RST_SLOW_SPEED; // [R4]
			fast_speed_q <= mcp_pkg::RST_FAST_SPEED; // [R5]
			jog_dist_q <= mcp_pkg::RST_JOG_DIST; // [R6]
			jog_step_q <= mcp_pkg::RST_JOG_STEP; // [R7]
			wait_time_q <= mcp_pkg::RST_WAIT_TIME; // [R8]
			ptp_speed_q <= DEF_PTP_SPEED; // [R14]
			irq_mask_q <= '0;
		end else if (reg_we_i) begin
			unique case (reg_addr_i)
				mcp_pkg::ADDR_CUR_LIMIT: cur_limit_q <= reg_wdata_i[15:0];
				mcp_pkg::ADDR_MAN_TYPE: begin
					// Only the two defined travel types are accepted.
					if (reg_wdata_i[15:1] == 15'h0000) begin
						man_type_q <= reg_wdata_i[15:0]; // [R3]
					end
				end
				mcp_pkg::ADDR_SLOW_SPEED: begin
					if (reg_wdata_i != 32'h0 && reg_wdata_i <= mcp_pkg::SPEED_MAX) begin
						slow_speed_q <= reg_wdata_i; // [R4]
					end
				end
				mcp_pkg::ADDR_FAST_SPEED: begin
					if (reg_wdata_i != 32'h0 && reg_wdata_i <= mcp_pkg::SPEED_MAX) begin
						fast_speed_q <= reg_wdata_i; // [R5]
					end
				end
				mcp_pkg::ADDR_JOG_DIST: begin
					if (reg_wdata_i[15:0] != 16'h0000) begin
						jog_dist_q <= reg_wdata_i[15:0]; // [R6]
					end
				end
				mcp_pkg::ADDR_JOG_STEP: jog_step_q <= reg_wdata_i[15:0]; // [R7]
				mcp_pkg::ADDR_WAIT_TIME: begin
					if (reg_wdata_i[15:0] != 16'h0000 && reg_wdata_i[15:0] <= mcp_pkg::WAIT_MAX) begin
						wait_time_q <= reg_wdata_i[15:0]; // [R8]
					end
				end
				mcp_pkg::ADDR_PTP_SPEED: begin
					if (reg_wdata_i != 32'h0 && reg_wdata_i <= mcp_pkg::SPEED_MAX) begin
						ptp_speed_q <= reg_wdata_i; // [R14]
					end
				end
				mcp_pkg::ADDR_IRQ_MASK: irq_mask_q <= reg_wdata_i[IRQ_W_L-1:0];
				default: begin
					// Commands and read-only words are handled elsewhere.
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Command words kept for read back.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			man_start_q <= 16'h0000;
			speed_cmd_q <= 32'h0;
			abs_cmd_q <= 32'h0;
			rel_cmd_q <= 32'h0;
			resume_cmd_q <= 16'h0000;
		end else begin
			if (wr_man_start) man_start_q <= reg_wdata_i[15:0];
			if (wr_speed) speed_cmd_q <= reg_wdata_i;
			if (wr_abs) abs_cmd_q <= reg_wdata_i;
			if (wr_rel) rel_cmd_q <= reg_wdata_i;
			if (wr_resume) resume_cmd_q <= reg_wdata_i[15:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Motion sequencer. A command write always takes priority over axis events.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_q <= S_IDLE;
			move_kind_o <= mcp_pkg::MCP_MOVE_NONE;
			move_start_o <= 1'b0;
			move_stop_o <= 1'b0;
			move_resume_o <= 1'b0;
			move_relative_o <= 1'b0;
			move_endless_o <= 1'b0;
			move_neg_o <= 1'b0;
			move_speed_o <= 32'h0;
			move_target_o <= 32'h0;
			ms_cyc_q <= 32'h0;
			ms_left_q <= 16'h0000;
		end else begin
			move_start_o <= 1'b0;
			move_stop_o <= 1'b0;
			move_resume_o <= 1'b0;
			if (wr_man_start) begin
				if (man_pos ^ man_neg) begin
					// Travel starts with the fixed step, or runs on if it is zero.
					move_kind_o <= mcp_pkg::MCP_MOVE_JOG; // [R2]
					move_neg_o <= man_neg; // [R2]
					move_speed_o <= man_fast ? fast_speed_q : slow_speed_q; // [R4] [R5]
					move_relative_o <= 1'b1;
					move_start_o <= 1'b1;
					if (jog_step_q != 16'h0000) begin
						move_target_o <= {16'h0000, jog_step_q}; // [R7]
						move_endless_o <= 1'b0;
						state_q <= S_MAN_STEP;
					end else begin
						move_target_o <= {16'h0000, jog_dist_q};
						move_endless_o <= (man_type_q == 16'h0000);
						state_q <= S_MAN_RUN;
					end
				end else begin
					// No direction, or both, halts manual travel.
					move_stop_o <= 1'b1;
					move_kind_o <= mcp_pkg::MCP_MOVE_NONE;
					state_q <= S_IDLE;
				end
			end else if (wr_speed) begin
				move_kind_o <= mcp_pkg::MCP_MOVE_VEL; // [R9]
				move_speed_o <= reg_wdata_i; // [R9]
				move_neg_o <= reg_wdata_i[31];
				move_endless_o <= 1'b1;
				move_relative_o <= 1'b0;
				move_start_o <= 1'b1;
				state_q <= S_VEL;
			end else if (wr_abs || wr_rel) begin
				move_kind_o <= mcp_pkg::MCP_MOVE_PTP;
				move_target_o <= reg_wdata_i; // [R11] [R12]
				move_relative_o <= wr_rel; // [R12]
				move_speed_o <= ptp_speed_q; // [R14]
				move_neg_o <= 1'b0;
				move_endless_o <= 1'b0;
				move_start_o <= 1'b1;
				state_q <= S_PTP;
			end else if (wr_resume) begin
				// The written value plays no part.
				if (state_q == S_PTP_HALT) begin
					move_resume_o <= 1'b1; // [R13]
					state_q <= S_PTP;
				end
			end else begin
				unique case (state_q)
					S_IDLE: begin
					end
					S_MAN_STEP: begin
						if (any_err) begin
							state_q <= S_IDLE;
						end else if (done_rise) begin
							if (man_type_q == 16'h0000) begin
								ms_left_q <= wait_time_q; // [R8]
								ms_cyc_q <= 32'h0;
								state_q <= S_MAN_WAIT;
							end else begin
								move_target_o <= {16'h0000, jog_dist_q}; // [R6]
								move_start_o <= 1'b1;
								state_q <= S_MAN_RUN;
							end
						end
					end
					S_MAN_WAIT: begin
						// Mode one: after the wait, travel continues without limit.
						if (any_err) begin
							state_q <= S_IDLE;
						end else if (ms_cyc_q == 32'(CYC_PER_MS - 1)) begin
							ms_cyc_q <= 32'h0;
							if (ms_left_q == 16'h0001) begin
								move_endless_o <= 1'b1; // [R8]
								move_start_o <= 1'b1;
								state_q <= S_MAN_RUN;
							end else begin
								ms_left_q <= ms_left_q - 16'h0001;
							end
						end else begin
							ms_cyc_q <= ms_cyc_q + 32'h1;
						end
					end
					S_MAN_RUN: begin
						// Mode two repeats a jog cycle each time one ends.
						if (any_err) begin
							state_q <= S_IDLE;
						end else if (done_rise && !move_endless_o) begin
							move_start_o <= 1'b1; // [R6]
						end
					end
					S_VEL: begin
						if (any_err) state_q <= S_IDLE;
					end
					S_PTP: begin
						// An error interrupts the move, it may then be resumed.
						if (any_err) begin
							state_q <= S_PTP_HALT;
						end else if (done_rise) begin
							state_q <= S_IDLE;
						end
					end
					S_PTP_HALT: begin
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Current limit: the manual limit applies only while manual travel is active.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			current_limit_o <= mcp_pkg::CUR_FULL;
		end else if (state_q == S_MAN_STEP || state_q == S_MAN_WAIT || state_q == S_MAN_RUN) begin
			current_limit_o <= cur_limit_q; // [R1]
		end else begin
			current_limit_o <= mcp_pkg::CUR_FULL;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Status words: cleared by a new command of their mode, then set by the axis; a stop also sets the speed end bit.
	logic man_act, vel_act, ptp_act;
	always_comb begin
		man_act = (move_kind_o == mcp_pkg::MCP_MOVE_JOG) && state_q != S_IDLE;
		vel_act = (move_kind_o == mcp_pkg::MCP_MOVE_VEL) && state_q != S_IDLE;
		ptp_act = (move_kind_o == mcp_pkg::MCP_MOVE_PTP) && state_q != S_IDLE;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			man_stat_q <= 16'h0000;
			vel_stat_q <= 16'h0000;
			ptp_stat_q <= 16'h0000;
		end else begin
			if (wr_man_start) begin
				man_stat_q <= 16'h0000;
			end else if (man_act && any_err) begin
				man_stat_q <= man_stat_q | err_bits | 16'hc000; // [R15]
			end else if (man_act && done_rise && !move_endless_o && state_q == S_MAN_RUN) begin
				man_stat_q[mcp_pkg::ST_END_BIT] <= 1'b1; // [R15]
			end
			if (wr_speed) begin
				vel_stat_q <= 16'h0000;
			end else if (vel_act && any_err) begin
				vel_stat_q <= vel_stat_q | err_bits | 16'hc000; // [R10]
			end else if (vel_act && reached_rise) begin
				vel_stat_q[mcp_pkg::ST_REACHED_BIT] <= 1'b1; // [R10]
			end
			if (wr_abs || wr_rel) begin
				ptp_stat_q <= 16'h0000;
			end else if (ptp_act && any_err) begin
				ptp_stat_q <= ptp_stat_q | err_bits | 16'h8000; // [R15]
			end else if (ptp_act && done_rise) begin
				ptp_stat_q[mcp_pkg::ST_END_BIT] <= 1'b1; // [R15]
				ptp_stat_q[mcp_pkg::ST_REACHED_BIT] <= in_q[8]; // [R15]
			end
			// A stop ends the speed profile.
			if (vel_act && wr_man_start && !(man_pos ^ man_neg)) begin
				vel_stat_q[mcp_pkg::ST_END_BIT] <= 1'b1; // [R10]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupts: sticky events, write one to clear, a set in the same cycle wins.
	always_comb begin
		irq_set = '0;
		irq_set[mcp_pkg::IRQ_MAN_END] = man_act && done_rise && state_q == S_MAN_RUN;
		irq_set[mcp_pkg::IRQ_VEL_END] = vel_act && any_err;
		irq_set[mcp_pkg::IRQ_VEL_REACHED] = vel_act && reached_rise;
		irq_set[mcp_pkg::IRQ_PTP_END] = ptp_act && done_rise;
		irq_set[mcp_pkg::IRQ_PTP_REACHED] = ptp_act && done_rise && in_q[8];
		irq_set[mcp_pkg::IRQ_ERROR] = err_rise;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			irq_stat_q <= '0;
			irq_o <= 1'b0;
		end else begin
			if (reg_we_i && reg_addr_i == mcp_pkg::ADDR_IRQ_STAT) begin
				irq_stat_q <= (irq_stat_q & ~reg_wdata_i[IRQ_W_L-1:0]) | irq_set;
			end else begin
				irq_stat_q <= irq_stat_q | irq_set;
			end
			irq_o <= |(irq_stat_q & irq_mask_q);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read port: data one cycle after the strobe, unmapped addresses read zero.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= 32'h0;
		end else if (reg_re_i) begin
			unique case (reg_addr_i)
				mcp_pkg::ADDR_CUR_LIMIT: reg_rdata_o <= {16'h0000, cur_limit_q};
				mcp_pkg::ADDR_MAN_START: reg_rdata_o <= {16'h0000, man_start_q};
				mcp_pkg::ADDR_MAN_STAT: reg_rdata_o <= {16'h0000, man_stat_q};
				mcp_pkg::ADDR_MAN_TYPE: reg_rdata_o <= {16'h0000, man_type_q};
				mcp_pkg::ADDR_SLOW_SPEED: reg_rdata_o <= slow_speed_q;
				mcp_pkg::ADDR_FAST_SPEED: reg_rdata_o <= fast_speed_q;
				mcp_pkg::ADDR_JOG_DIST: reg_rdata_o <= {16'h0000, jog_dist_q};
				mcp_pkg::ADDR_JOG_STEP: reg_rdata_o <= {16'h0000, jog_step_q};
				mcp_pkg::ADDR_WAIT_TIME: reg_rdata_o <= {16'h0000, wait_time_q};
				mcp_pkg::ADDR_SPEED_CMD: reg_rdata_o <= speed_cmd_q;
				mcp_pkg::ADDR_VEL_STAT: reg_rdata_o <= {16'h0000, vel_stat_q};
				mcp_pkg::ADDR_ABS_CMD: reg_rdata_o <= abs_cmd_q;
				mcp_pkg::ADDR_PTP_STAT: reg_rdata_o <= {16'h0000, ptp_stat_q};
				mcp_pkg::ADDR_REL_CMD: reg_rdata_o <= rel_cmd_q;
				mcp_pkg::ADDR_RESUME_CMD: reg_rdata_o <= {16'h0000, resume_cmd_q};
				mcp_pkg::ADDR_PTP_SPEED: reg_rdata_o <= ptp_speed_q;
				mcp_pkg::ADDR_IRQ_STAT: reg_rdata_o <= 32'(irq_stat_q);
				mcp_pkg::ADDR_IRQ_MASK: reg_rdata_o <= 32'(irq_mask_q);
				mcp_pkg::ADDR_AXIS_STATE: reg_rdata_o <= {29'h0, state_q};
				default: reg_rdata_o <= 32'h0;
			endcase
		end else begin
			reg_rdata_o <= 32'h0;
		end
	end

endmodule

// file: design/mcp_pkg.sv
package mcp_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register byte addresses on the plain register port.
	localparam logic [7:0] ADDR_CUR_LIMIT = 8'h00;
	localparam logic [7:0] ADDR_MAN_START = 8'h04;
	localparam logic [7:0] ADDR_MAN_STAT = 8'h08;
	localparam logic [7:0] ADDR_MAN_TYPE = 8'h0c;
	localparam logic [7:0] ADDR_SLOW_SPEED = 8'h10;
	localparam logic [7:0] ADDR_FAST_SPEED = 8'h14;
	localparam logic [7:0] ADDR_JOG_DIST = 8'h18;
	localparam logic [7:0] ADDR_JOG_STEP = 8'h1c;
	localparam logic [7:0] ADDR_WAIT_TIME = 8'h20;
	localparam logic [7:0] ADDR_SPEED_CMD = 8'h24;
	localparam logic [7:0] ADDR_VEL_STAT = 8'h28;
	localparam logic [7:0] ADDR_ABS_CMD = 8'h2c;
	localparam logic [7:0] ADDR_PTP_STAT = 8'h30;
	localparam logic [7:0] ADDR_REL_CMD = 8'h34;
	localparam logic [7:0] ADDR_RESUME_CMD = 8'h38;
	localparam logic [7:0] ADDR_PTP_SPEED = 8'h3c;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h40;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h44;
	localparam logic [7:0] ADDR_AXIS_STATE = 8'h48;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values.
	localparam logic [15:0] RST_CUR_LIMIT = 16'h03e8;
	localparam logic [15:0] RST_MAN_TYPE = 16'h0000;
	localparam logic [31:0] RST_SLOW_SPEED = 32'h0000003c;
	localparam logic [31:0] RST_FAST_SPEED = 32'h000000b4;
	localparam logic [15:0] RST_JOG_DIST = 16'h0014;
	localparam logic [15:0] RST_JOG_STEP = 16'h0014;
	localparam logic [15:0] RST_WAIT_TIME = 16'h03e8;
	localparam logic [31:0] RST_PTP_SPEED = 32'h0000003c;
	localparam logic [15:0] CUR_FULL = 16'hffff;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions, masks and limits.
	localparam int MAN_POS_BIT = 0;
	localparam int MAN_NEG_BIT = 1;
	localparam int MAN_FAST_BIT = 2;
	localparam int ST_REACHED_BIT = 13;
	localparam int ST_END_BIT = 14;
	localparam int ST_ERR_BIT = 15;
	localparam logic [15:0] ERR_FIELD_MASK = 16'h00ef;
	localparam logic [15:0] WAIT_MAX = 16'h7530;
	localparam logic [31:0] SPEED_MAX = 32'h7fffffff;

	// Interrupt status bit positions.
	localparam int IRQ_MAN_END = 0;
	localparam int IRQ_VEL_END = 1;
	localparam int IRQ_VEL_REACHED = 2;
	localparam int IRQ_PTP_END = 3;
	localparam int IRQ_PTP_REACHED = 4;
	localparam int IRQ_ERROR = 5;
	localparam int IRQ_W = 6;

	////////////////////////////////////////////////////////////////////////////////
	// Timing.
	localparam int CLK_PERIOD_PS = 4000;
	localparam int WAIT_UNIT_PS = 1000000000;
	localparam int CYC_PER_MS = WAIT_UNIT_PS / CLK_PERIOD_PS;

	// Motion kinds presented to the axis.
	typedef enum logic [1:0] {
		MCP_MOVE_NONE,
		MCP_MOVE_JOG,
		MCP_MOVE_VEL,
		MCP_MOVE_PTP
	} mcp_move_t;

endpackage

// file: test/mcp_axis_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Axis that arrives a fixed number of cycles after each start; a fault holds it.
module mcp_axis_model #(
	parameter int DLY = 20 // Cycles from start to arrival.
) (
	input wire logic clk_i, // Clock.
	input wire logic start_i, // New motion.
	input wire logic resume_i, // Resume a halted motion.
	input wire logic [7:0] err_req_i, // Fault ordered by the bench.
	output logic [7:0] err_o, // Error flags.
	output logic reached_o, // At setpoint.
	output logic done_o // Motion finished.
);
	int cnt = 0; // Cycles into the motion.
	logic run = 0; // Set by the first start, so no arrival shows before it.
	// A start or resume restarts the count; a fault freezes it.
	always @(posedge clk_i) begin
		if (start_i || resume_i) begin
			cnt <= 0;
			run <= 1;
		end else if (err_req_i == 8'h0 && cnt < DLY) begin
			cnt <= cnt + 1;
		end
	end
	assign err_o = err_req_i;
	assign reached_o = run && cnt == DLY;
	assign done_o = run && cnt == DLY;
endmodule

// file: test/mcp_motion_command_params_assertions.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Port checks of the motion command block.
module mcp_motion_command_params_assertions (
	input wire logic clk_i, // Clock.
	input wire logic sys_rst_i, // Reset.
	input wire logic [7:0] reg_addr_i, // Address.
	input wire logic [31:0] reg_wdata_i, // Write data.
	input wire logic reg_we_i, // Write strobe.
	input wire logic reg_re_i, // Read strobe.
	input wire logic [31:0] reg_rdata_o, // Read data.
	input wire mcp_pkg::mcp_move_t move_kind_o, // Motion kind.
	input wire logic move_start_o, // Start pulse.
	input wire logic move_stop_o, // Halt pulse.
	input wire logic move_resume_o, // Resume pulse.
	input wire logic move_relative_o, // Distance target.
	input wire logic move_neg_o, // Negative sense.
	input wire logic [31:0] move_speed_o, // Speed.
	input wire logic [31:0] move_target_o, // Target.
	input wire logic [15:0] current_limit_o // Current limit.
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	logic wr_q; // A write strobe is present.
	assign wr_q = reg_we_i;
	rd_slot_a: assert property (reg_rdata_o != 32'h0 |-> $past(reg_re_i))
		else $error("Read data outside its slot.");
	speed_start_a: assert property (wr_q && reg_addr_i == mcp_pkg::ADDR_SPEED_CMD |=>
		move_start_o && move_kind_o == mcp_pkg::MCP_MOVE_VEL && move_speed_o == $past(reg_wdata_i))
		else $error("Speed command not launched.");
	abs_start_a: assert property (wr_q && reg_addr_i == mcp_pkg::ADDR_ABS_CMD |=> move_start_o &&
		!move_relative_o && move_target_o == $past(reg_wdata_i))
		else $error("Absolute move not launched.");
	rel_start_a: assert property (wr_q && reg_addr_i == mcp_pkg::ADDR_REL_CMD |=> move_start_o &&
		move_relative_o && move_target_o == $past(reg_wdata_i))
		else $error("Relative move not launched.");
	resume_a: assert property (move_resume_o |->
		$past(reg_we_i) && $past(reg_addr_i) == mcp_pkg::ADDR_RESUME_CMD)
		else $error("Resume without a resume write.");
	man_dir_a: assert property (wr_q && reg_addr_i == mcp_pkg::ADDR_MAN_START &&
		(reg_wdata_i[0] ^ reg_wdata_i[1]) |=> move_start_o && move_neg_o == $past(reg_wdata_i[1]))
		else $error("Manual start wrong.");
	bad_dir_a: assert property (wr_q && reg_addr_i == mcp_pkg::ADDR_MAN_START &&
		reg_wdata_i[0] == reg_wdata_i[1] |=> move_stop_o && !move_start_o)
		else $error("Start without one direction not halted.");
	cur_full_a: assert property (move_kind_o != mcp_pkg::MCP_MOVE_JOG &&
		$past(move_kind_o) != mcp_pkg::MCP_MOVE_JOG |-> current_limit_o == mcp_pkg::CUR_FULL)
		else $error("Current limited outside manual travel.");
	start_kind_a: assert property (move_start_o |-> move_kind_o != mcp_pkg::MCP_MOVE_NONE)
		else $error("Start without a motion kind.");
endmodule
bind mcp_motion_command_params mcp_motion_command_params_assertions u_chk (.clk_i, .sys_rst_i,
	.reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o, .move_kind_o, .move_start_o,
	.move_stop_o, .move_resume_o, .move_relative_o, .move_neg_o, .move_speed_o, .move_target_o,
	.current_limit_o);

// file: test/mcp_motion_command_params_tb.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Register-level tests of the motion command block against a simple axis.
module mcp_motion_command_params_tb;
	logic clk_i = 0, sys_rst_i = 1, reg_we_i = 0, reg_re_i = 0;
	logic [7:0] reg_addr_i = 0, axis_err_i, err_req = 0;
	logic [31:0] reg_wdata_i = 0, reg_rdata_o, move_speed_o, move_target_o;
	logic axis_reached_i, axis_done_i, move_start_o, move_stop_o, move_resume_o, irq_o;
	logic move_relative_o, move_endless_o, move_neg_o;
	logic [15:0] current_limit_o;
	mcp_pkg::mcp_move_t move_kind_o;
	int n_fail = 0, samples_checked = 0, cyc = 0, n_res = 0;
	always #2 clk_i = ~clk_i;
	mcp_motion_command_params #(.CYC_PER_MS(4)) DUT (.clk_i, .sys_rst_i, .reg_addr_i,
		.reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o, .axis_err_i, .axis_reached_i,
		.axis_done_i, .move_kind_o, .move_start_o, .move_stop_o, .move_resume_o,
		.move_relative_o, .move_endless_o, .move_neg_o, .move_speed_o, .move_target_o,
		.current_limit_o, .irq_o);
	mcp_axis_model AX (.clk_i(clk_i), .start_i(move_start_o), .resume_i(move_resume_o),
		.err_req_i(err_req), .err_o(axis_err_i), .reached_o(axis_reached_i), .done_o(axis_done_i));
	// Counts resume pulses and cuts a hung run short.
	always @(posedge clk_i) begin
		cyc++;
		if (move_resume_o)
			n_res++;
		if (cyc == 5000) begin
			n_fail++;
			results();
		end
	end
	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", n, e, g);
			n_fail++;
		end
	endtask
	// One write cycle, then one idle cycle so strobes never collide.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_we_i <= 1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_we_i <= 0;
		@(posedge clk_i);
	endtask
	// Read data is taken in the one cycle after the strobe.
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
		reg_re_i <= 1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_re_i <= 0;
		@(posedge clk_i);
		chk("read data", e, reg_rdata_o & m);
	endtask
	initial begin
		repeat (8) @(posedge clk_i);
		sys_rst_i <= 0;
		@(posedge clk_i);
		// Reset values, refused writes and an unmapped place.
		rd(mcp_pkg::ADDR_CUR_LIMIT, 32'h3e8);
		rd(mcp_pkg::ADDR_JOG_DIST, 32'h14);
		rd(mcp_pkg::ADDR_JOG_STEP, 32'h14);
		rd(mcp_pkg::ADDR_PTP_SPEED, 32'h3c);
		wr(mcp_pkg::ADDR_SLOW_SPEED, 32'h0);
		wr(mcp_pkg::ADDR_FAST_SPEED, 32'h80000000);
		wr(mcp_pkg::ADDR_MAN_TYPE, 32'h2);
		rd(mcp_pkg::ADDR_SLOW_SPEED, 32'h3c);
		rd(mcp_pkg::ADDR_FAST_SPEED, 32'hb4);
		rd(mcp_pkg::ADDR_MAN_TYPE, 32'h0);
		rd(8'h4c, 32'h0);
		$display("test registers done");
		// Speed profile, reached flag and its interrupt.
		wr(mcp_pkg::ADDR_IRQ_MASK, 32'h4);
		wr(mcp_pkg::ADDR_SPEED_CMD, 32'hfffffff0);
		for (int i = 0; i < 60 && !irq_o; i++) @(posedge clk_i);
		chk("irq", 32'h1, 32'(irq_o));
		rd(mcp_pkg::ADDR_VEL_STAT, 32'h2000, 32'h2000);
		wr(mcp_pkg::ADDR_IRQ_STAT, 32'h4);
		@(posedge clk_i);
		chk("irq cleared", 32'h0, 32'(irq_o));
		$display("test speed done");
		// Absolute move to its end, then relative move broken by a fault and resumed.
		wr(mcp_pkg::ADDR_ABS_CMD, 32'hfffffffb);
		chk("point speed", 32'h3c, move_speed_o);
		repeat (32) @(posedge clk_i);
		rd(mcp_pkg::ADDR_PTP_STAT, 32'h6000);
		wr(mcp_pkg::ADDR_REL_CMD, 32'h100);
		err_req <= 8'h01;
		repeat (8) @(posedge clk_i);
		rd(mcp_pkg::ADDR_PTP_STAT, 32'h8001);
		err_req <= 8'h00;
		repeat (5) @(posedge clk_i);
		wr(mcp_pkg::ADDR_RESUME_CMD, 32'h1234);
		@(posedge clk_i);
		chk("resume", 32'h1, 32'(n_res));
		$display("test point done");
		// Mode one: step, short wait, then endless fast travel.
		wr(mcp_pkg::ADDR_WAIT_TIME, 32'h2);
		wr(mcp_pkg::ADDR_MAN_START, 32'h5);
		@(posedge clk_i);
		chk("limit", 32'h3e8, 32'(current_limit_o));
		chk("step", 32'h14, move_target_o);
		for (int i = 0; i < 80 && !move_endless_o; i++) @(posedge clk_i);
		chk("endless", 32'h1, 32'(move_endless_o));
		chk("fast", 32'hb4, move_speed_o);
		wr(mcp_pkg::ADDR_MAN_START, 32'h3);
		// Mode two: negative slow travel in jog cycles.
		wr(mcp_pkg::ADDR_MAN_TYPE, 32'h1);
		wr(mcp_pkg::ADDR_JOG_DIST, 32'h30);
		wr(mcp_pkg::ADDR_MAN_START, 32'h2);
		chk("neg", 32'h1, 32'(move_neg_o));
		for (int i = 0; i < 80 && move_target_o !== 32'h30; i++) @(posedge clk_i);
		chk("jog", 32'h30, move_target_o);
		chk("slow", 32'h3c, move_speed_o);
		wr(mcp_pkg::ADDR_MAN_START, 32'h0);
		$display("test manual done");
		results();
	end
endmodule
